// *** design/bpss_pkg.sv ***
// bpss_pkg: constants and types of the board power-state sequencer
package bpss_pkg;

    localparam int unsigned CLK_HZ          = 25_000_000;
    // press thresholds in milliseconds and derived cycle counts
    localparam int unsigned SHORT_PRESS_MS  = 4000;
    localparam int unsigned LONG_PRESS_MS   = 6000;
    localparam int unsigned SHORT_PRESS_CYC = SHORT_PRESS_MS * (CLK_HZ / 1000);
    localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_MS * (CLK_HZ / 1000);
    localparam int unsigned PRESS_CNT_W     = 28;

    // fan pwm
    localparam int unsigned FAN_NUM         = 2;
    localparam int unsigned PWM_W           = 8;
    localparam logic [7:0]  PWM_FULL        = 8'hff;

    typedef enum logic [4:0] {
        BPSS_S0    = 5'b0_0001,
        BPSS_S3    = 5'b0_0010,
        BPSS_S4    = 5'b0_0100,
        BPSS_S5    = 5'b0_1000,
        BPSS_G3    = 5'b1_0000
    } bpss_state_e;

    // context location encoding
    localparam logic [1:0] CTX_NONE = 2'h0;
    localparam logic [1:0] CTX_RAM  = 2'h1;
    localparam logic [1:0] CTX_DISK = 2'h2;

endpackage : bpss_pkg

// *** design/bpss_fan_pwm.sv ***
// bpss_fan_pwm: one fan channel, pwm generator with forced on/off
module bpss_fan_pwm
    import bpss_pkg::*;
(
    input  wire logic             mclk_in,     // system clock
    input  wire logic             reset_n_in,  // async reset, active low
    input  wire logic             enable_in,   // fan allowed to run
    input  wire logic             force_on_in, // full speed override
    input  wire logic [PWM_W-1:0] duty_in,     // closed-loop duty
    output logic                  pwm_out      // pwm drive, registered
);

    logic [PWM_W-1:0] phase_reg;

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            phase_reg <= '0;
        else
            phase_reg <= phase_reg + 1'b1;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            pwm_out <= 1'b0;
        else if (!enable_in)
            pwm_out <= 1'b0;
        else if (force_on_in || duty_in == PWM_FULL)
            pwm_out <= 1'b1;
        else
            pwm_out <= (phase_reg < duty_in);
    end

endmodule : bpss_fan_pwm

// *** design/bpss_top.sv ***
// bpss_top: board power-state sequencer with switch timing, wake, fans and intrusion
module bpss_top
    import bpss_pkg::*;
#(
    parameter int unsigned SHORT_CYC = SHORT_PRESS_CYC, // short press limit in cycles
    parameter int unsigned LONG_CYC  = LONG_PRESS_CYC   // long press limit in cycles
)
(
    input  wire logic                mclk_in,           // 25 MHz standby clock
    input  wire logic                reset_n_in,        // async reset, active low
    input  wire logic                pwr_sw_n_in,       // power switch pin, low pressed
    input  wire logic                rtc_alarm_in,      // rtc alarm pin
    input  wire logic                lan_wake_in,       // lan wake pin
    input  wire logic                usb_wake_in,       // usb activity pin
    input  wire logic                pcie_wake_n_in,    // pcie wake pin, low active
    input  wire logic                sleep_s3_cmd_in,   // os request: suspend to ram
    input  wire logic                sleep_s4_cmd_in,   // os request: suspend to disk
    input  wire logic                shutdown_cmd_in,   // os request: soft-off
    input  wire logic                ac_ok_in,          // ac mains present pin
    input  wire logic                restore_en_in,     // restore last on/off state after ac loss
    input  wire logic                chassis_sw_in,     // intrusion switch pin, high closed
    input  wire logic                intr_clear_in,     // clear intrusion flag
    input  wire logic [FAN_NUM-1:0]  fan_tach_in,       // per-fan tachometer pins
    input  wire logic [PWM_W-1:0]    fan_duty_in,       // closed-loop duty, same clock
    input  wire logic [FAN_NUM-1:0]  fan_full_in,       // per-fan full-on request
    output logic                     main_rails_on_out, // drive for non-standby rails
    output logic [4:0]               state_out,         // current power state one-hot
    output logic [1:0]               ctx_loc_out,       // where context is held
    output logic                     cold_boot_out,     // next wake needs a cold boot
    output logic [FAN_NUM-1:0]       fan_pwm_out,       // per-fan pwm drive
    output logic [FAN_NUM-1:0]       fan_tach_mon_out,  // per-fan synced tach to monitor
    output logic                     intrusion_out      // chassis intrusion flag
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned SYNC_W = 8 + FAN_NUM;

    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;

    assign pin_raw = {fan_tach_in, ~pwr_sw_n_in, rtc_alarm_in, lan_wake_in, usb_wake_in,
                      ~pcie_wake_n_in, ac_ok_in, chassis_sw_in, restore_en_in};

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    logic sw_pressed;
    logic rtc_s;
    logic lan_s;
    logic usb_s;
    logic pcie_s;
    logic ac_s;
    logic chassis_s;
    logic restore_s;
    logic [FAN_NUM-1:0] tach_s;

    assign {tach_s, sw_pressed, rtc_s, lan_s, usb_s, pcie_s, ac_s, chassis_s, restore_s}
        = sync2_reg;

    // ------------------------------------------------------------
    // power switch press timer
    // ------------------------------------------------------------
    logic [PRESS_CNT_W-1:0] press_cnt_reg;
    logic                   sw_prev_reg;
    logic                   long_done_reg;
    logic                   short_release;
    logic                   long_hit;

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            sw_prev_reg <= 1'b0;
        else
            sw_prev_reg <= sw_pressed;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            press_cnt_reg <= '0;
        else if (!sw_pressed)
            press_cnt_reg <= '0;
        else if (press_cnt_reg != PRESS_CNT_W'(LONG_CYC))
            press_cnt_reg <= press_cnt_reg + 1'b1;
    end

    // release before the short limit counts as a short press
    assign short_release = sw_prev_reg && !sw_pressed
                           && (press_cnt_reg < PRESS_CNT_W'(SHORT_CYC));
    // fail-safe fires once the hold passes the long limit, even while still held
    assign long_hit = sw_pressed && !long_done_reg
                      && (press_cnt_reg == PRESS_CNT_W'(LONG_CYC));

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            long_done_reg <= 1'b0;
        else if (!sw_pressed)
            long_done_reg <= 1'b0;
        else if (long_hit)
            long_done_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // wake decode
    // ------------------------------------------------------------
    logic wake_common;
    logic wake_s3;
    logic wake_s45;

    assign wake_common = rtc_s || lan_s || pcie_s;
    assign wake_s3     = wake_common || usb_s;
    assign wake_s45    = wake_common;

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    bpss_state_e state_reg;
    bpss_state_e state_next;
    logic        last_on_reg;
    logic        ac_prev_reg;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            BPSS_S0:
            begin
                if (!ac_s)
                    state_next = BPSS_G3;
                else if (long_hit || shutdown_cmd_in)
                    state_next = BPSS_S5;
                else if (short_release || sleep_s3_cmd_in)
                    state_next = BPSS_S3;
                else if (sleep_s4_cmd_in)
                    state_next = BPSS_S4;
            end
            BPSS_S3:
            begin
                if (!ac_s)
                    state_next = BPSS_G3;
                else if (long_hit)
                    state_next = BPSS_S5;
                else if (short_release || wake_s3)
                    state_next = BPSS_S0;
            end
            BPSS_S4:
            begin
                if (!ac_s)
                    state_next = BPSS_G3;
                else if (long_hit)
                    state_next = BPSS_S5;
                else if (short_release || wake_s45)
                    state_next = BPSS_S0;
            end
            BPSS_S5:
            begin
                if (!ac_s)
                    state_next = BPSS_G3;
                else if (short_release || wake_s45)
                    state_next = BPSS_S0;
            end
            BPSS_G3:
            begin
                if (ac_s && !ac_prev_reg)
                    state_next = (restore_s && last_on_reg) ? BPSS_S0 : BPSS_S5;
            end
            default:
                state_next = BPSS_S5;
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state_reg <= BPSS_G3;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            ac_prev_reg <= 1'b0;
        else
            ac_prev_reg <= ac_s;
    end

    // remembers on/off across the loss; not updated while in G3
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            last_on_reg <= 1'b0;
        else if (state_reg != BPSS_G3)
            last_on_reg <= (state_reg == BPSS_S0);
    end

    // ------------------------------------------------------------
    // supply control and state outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            main_rails_on_out <= 1'b0;
            state_out         <= BPSS_G3;
            ctx_loc_out       <= CTX_NONE;
            cold_boot_out     <= 1'b1;
        end
        else
        begin
            main_rails_on_out <= (state_next == BPSS_S0);
            state_out         <= state_next;
            case (state_next)
                BPSS_S3: ctx_loc_out <= CTX_RAM;
                BPSS_S4: ctx_loc_out <= CTX_DISK;
                default: ctx_loc_out <= CTX_NONE;
            endcase
            cold_boot_out     <= (state_next == BPSS_S5)
                                 || (state_next == BPSS_G3);
        end
    end

    // ------------------------------------------------------------
    // fans
    // ------------------------------------------------------------
    logic fan_en_reg;

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            fan_en_reg <= 1'b0;
        else
            fan_en_reg <= (state_next == BPSS_S0);
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            fan_tach_mon_out <= '0;
        else
            fan_tach_mon_out <= tach_s;
    end

    genvar gi;
    generate
        for (gi = 0; gi < FAN_NUM; gi++)
        begin : g_fan
            bpss_fan_pwm u_fan (
                .mclk_in     (mclk_in),
                .reset_n_in  (reset_n_in),
                .enable_in   (fan_en_reg),
                .force_on_in (fan_full_in[gi]),
                .duty_in     (fan_duty_in),
                .pwm_out     (fan_pwm_out[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // chassis intrusion
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            intrusion_out <= 1'b0;
        else if (chassis_s)
            intrusion_out <= 1'b1;
        else if (intr_clear_in)
            intrusion_out <= 1'b0;
    end

endmodule : bpss_top

// *** dv/bpss_top_asserts.sv ***
// bpss_top_asserts: port-level checker for the power-state sequencer
module bpss_top_checker
    import bpss_pkg::*;
#(
    parameter int unsigned SHORT_CYC = SHORT_PRESS_CYC, // short press limit
    parameter int unsigned LONG_CYC  = LONG_PRESS_CYC   // long press limit
)
(
    input  wire logic               mclk_in,           // clock
    input  wire logic               reset_n_in,        // reset, active low
    input  wire logic               shutdown_cmd_in,   // soft-off request
    input  wire logic               chassis_sw_in,     // intrusion switch
    input  wire logic               intr_clear_in,     // intrusion clear
    input  wire logic [FAN_NUM-1:0] fan_tach_in,       // tach pins
    input  wire logic [PWM_W-1:0]   fan_duty_in,       // duty
    input  wire logic               main_rails_on_out, // rails drive
    input  wire logic [4:0]         state_out,         // power state
    input  wire logic [1:0]         ctx_loc_out,       // context place
    input  wire logic               cold_boot_out,     // cold boot flag
    input  wire logic [FAN_NUM-1:0] fan_pwm_out,       // fan drive
    input  wire logic [FAN_NUM-1:0] fan_tach_mon_out,  // tach to monitor
    input  wire logic               intrusion_out      // intrusion flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // ----------------------------------------
    // state, fan and intrusion steps
    // ----------------------------------------
    sequence s_off_cmd;
        state_out == BPSS_S0 && shutdown_cmd_in;
    endsequence
    sequence s_full_run;
        (state_out == BPSS_S0 && fan_duty_in == PWM_FULL)[*3];
    endsequence
    sequence s_not_working;
        (state_out != BPSS_S0)[*2];
    endsequence
    a_rails_follow_s0: assert property (main_rails_on_out == (state_out == BPSS_S0))
        else $error("rails do not follow working state");
    a_off_cmd_s5: assert property (s_off_cmd |=> state_out == BPSS_S5)
        else $error("shutdown did not reach soft-off");
    a_ctx_in_ram: assert property (state_out == BPSS_S3 |-> ctx_loc_out == CTX_RAM)
        else $error("S3 context not in ram");
    a_ctx_on_disk: assert property (state_out == BPSS_S4 |-> ctx_loc_out == CTX_DISK)
        else $error("S4 context not on disk");
    a_cold_boot_s5: assert property (state_out == BPSS_S5 |-> cold_boot_out)
        else $error("S5 without cold boot flag");
    a_fans_off_sleep: assert property (s_not_working |-> fan_pwm_out == '0)
        else $error("fan driven outside working state");
    a_fans_full_on: assert property (s_full_run |=> fan_pwm_out == '1)
        else $error("fan not full in working state");
    a_tach_each_fan: assert property (fan_tach_mon_out == $past(fan_tach_in, 3))
        else $error("tach path wrong");
    a_intr_raise: assert property (chassis_sw_in |-> ##[1:4] intrusion_out)
        else $error("intrusion not raised");
    a_intr_sticky: assert property (intrusion_out && !intr_clear_in |=> intrusion_out)
        else $error("intrusion flag dropped");
endmodule : bpss_top_checker

bind bpss_top bpss_top_checker #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) bpss_top_checker_inst (
    .mclk_in, .reset_n_in, .shutdown_cmd_in, .chassis_sw_in, .intr_clear_in, .fan_tach_in,
    .fan_duty_in, .main_rails_on_out, .state_out, .ctx_loc_out, .cold_boot_out, .fan_pwm_out,
    .fan_tach_mon_out, .intrusion_out);

// *** dv/bpss_panel_model.sv ***
// bpss_panel_model: front panel switch and wake source model
module bpss_panel_model
(
    input  wire logic       mclk_in,         // clock
    input  wire logic       press_in,        // start a press
    input  wire logic [7:0] hold_in,         // press length in cycles
    input  wire logic [3:0] wake_in,         // rtc, lan, usb, pcie requests
    output logic            pwr_sw_n_out,    // switch pin, low pressed
    output logic [2:0]      wake_out,        // rtc, lan, usb pins
    output logic            pcie_wake_n_out  // pcie wake pin, low active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg  = 8'h00;
    logic [3:0] wake_reg = 4'h0;
    always_ff @(posedge mclk_in)
    begin
        if (press_in)
            cnt_reg <= hold_in;
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
    end
    always_ff @(posedge mclk_in)
        wake_reg <= wake_in;
    assign pwr_sw_n_out    = (cnt_reg == 8'h00);
    assign wake_out        = wake_reg[2:0];
    assign pcie_wake_n_out = !wake_reg[3];
endmodule : bpss_panel_model

// *** dv/bpss_top_bench.sv ***
// bpss_top_bench: self-checking bench of the power-state sequencer
module bpss_top_bench;
    import bpss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, press = 1'b0, ac = 1'b0, restore = 1'b0;
    logic chassis = 1'b0, clr = 1'b0, sw_n, pcie_n, rails, cold, intr;
    logic [7:0] hold = 8'h00, duty = 8'h00;
    logic [3:0] wake = 4'h0;
    logic [2:0] cmd = 3'h0, wk;
    logic [1:0] tach = 2'h0, full = 2'h0, ctx, pwm, mon;
    logic [4:0] state, last = BPSS_G3;
    logic [31:0] seed = 32'h096f_ebaf;
    int fail_count = 0, compares = 0;
    bpss_state_e expq[$];
    bpss_state_e e;
    always #20 clk = ~clk;
    bpss_panel_model bpss_panel_model_inst (.mclk_in(clk), .press_in(press), .hold_in(hold),
        .wake_in(wake), .pwr_sw_n_out(sw_n), .wake_out(wk), .pcie_wake_n_out(pcie_n));
    bpss_top #(.SHORT_CYC(20), .LONG_CYC(30)) bpss_top_inst (.mclk_in(clk), .reset_n_in(rst_n),
        .pwr_sw_n_in(sw_n), .rtc_alarm_in(wk[0]), .lan_wake_in(wk[1]), .usb_wake_in(wk[2]),
        .pcie_wake_n_in(pcie_n), .sleep_s3_cmd_in(cmd[0]), .sleep_s4_cmd_in(cmd[1]),
        .shutdown_cmd_in(cmd[2]), .ac_ok_in(ac), .restore_en_in(restore),
        .chassis_sw_in(chassis), .intr_clear_in(clr), .fan_tach_in(tach), .fan_duty_in(duty),
        .fan_full_in(full), .main_rails_on_out(rails), .state_out(state), .ctx_loc_out(ctx),
        .cold_boot_out(cold), .fan_pwm_out(pwm), .fan_tach_mon_out(mon), .intrusion_out(intr));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic bad(input logic [7:0] g, input logic [7:0] x);
        fail_count++;
        $display("BAD %0t got %h exp %h", $time, g, x);
    endtask : bad
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        compares++;
        if (g !== x) bad(g, x);
    endtask : chk
    task automatic results();
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic wait_q();
        int i;
        i = 0;
        while (expq.size() != 0 && i < 200)
        begin
            tick(1);
            i++;
        end
        if (expq.size() != 0)
        begin
            fail_count++;
            results();
        end
    endtask : wait_q
    task automatic sw(input bpss_state_e x, input logic [7:0] n);
        expq.push_back(x);
        hold = n;
        press = 1'b1;
        tick(1);
        press = 1'b0;
        wait_q();
        // let a long hold run out and the synced pin settle before the next press
        tick(int'(n) + 4);
    endtask : sw
    task automatic quiet(input bpss_state_e x, input logic [7:0] n);
        hold = n;
        press = 1'b1;
        tick(1);
        press = 1'b0;
        tick(70);
        chk(8'(state), 8'(x));
    endtask : quiet
    task automatic go(input bpss_state_e x, input logic [2:0] c, input logic [3:0] w);
        expq.push_back(x);
        cmd = c;
        wake = w;
        tick(1);
        cmd = 3'h0;
        wait_q();
        wake = 4'h0;
        tick(8);
    endtask : go
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge clk)
    begin
        #1;
        if (rst_n && state !== last)
        begin
            compares++;
            if (expq.size() == 0) bad(8'(state), 8'(last));
            else
            begin
                e = expq.pop_front();
                if (e !== state) bad(8'(state), 8'(e));
            end
            last = state;
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        tick(12);
        rst_n = 1'b1;
        tick(5);
        expq.push_back(BPSS_S5);
        ac = 1'b1;
        wait_q();
        sw(BPSS_S0, 8'd5);
        sw(BPSS_S3, 8'd5);
        sw(BPSS_S0, 8'd5);
        quiet(BPSS_S0, 8'd25);
        $display("test press timing done");
        for (int w = 0; w < 4; w++)
            for (int k = 0; k < 3; k++)
            begin
                go(k == 0 ? BPSS_S3 : (k == 1 ? BPSS_S4 : BPSS_S5), 3'(1 << k), 4'h0);
                if (w == 2 && k != 0)
                begin
                    wake = 4'h4;
                    tick(40);
                    chk(8'(state), k == 1 ? 8'(BPSS_S4) : 8'(BPSS_S5));
                    go(BPSS_S0, 3'h0, 4'h1);
                end
                else go(BPSS_S0, 3'h0, 4'(1 << w));
            end
        $display("test wake sources done");
        sw(BPSS_S5, 8'd40);
        sw(BPSS_S0, 8'd5);
        sw(BPSS_S3, 8'd5);
        sw(BPSS_S5, 8'd40);
        quiet(BPSS_S5, 8'd40);
        sw(BPSS_S0, 8'd5);
        $display("test long press done");
        duty = PWM_FULL;
        tick(10);
        chk(8'(pwm), 8'h03);
        chk(8'(rails), 8'h01);
        for (int i = 0; i < 300; i++)
        begin
            seed = xs(seed);
            {full, tach, duty} = seed[11:0];
            tick(1);
        end
        full = 2'b01;
        duty = 8'h00;
        tick(3);
        chk(8'(pwm), 8'h01);
        full = 2'b00;
        tick(3);
        chk(8'(pwm), 8'h00);
        go(BPSS_S3, 3'h1, 4'h0);
        chk(8'(pwm), 8'h00);
        go(BPSS_S0, 3'h0, 4'h1);
        $display("test fans done");
        restore = 1'b1;
        tick(4);
        expq.push_back(BPSS_G3);
        ac = 1'b0;
        wait_q();
        tick(5);
        expq.push_back(BPSS_S0);
        ac = 1'b1;
        wait_q();
        restore = 1'b0;
        expq.push_back(BPSS_G3);
        ac = 1'b0;
        wait_q();
        tick(5);
        expq.push_back(BPSS_S5);
        ac = 1'b1;
        wait_q();
        $display("test ac restore done");
        chassis = 1'b1;
        tick(2);
        chassis = 1'b0;
        tick(6);
        chk(8'(intr), 8'h01);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(3);
        chk(8'(intr), 8'h00);
        $display("test intrusion done");
        results();
    end
endmodule : bpss_top_bench
